//--- common/hla_consts.svh
// Purpose: Constants for the host link and audio/radio control block
// Assumes: 50 MHz reference clock
// Notes: Frame dividers round down to whole cycles
`ifndef HLA_CONSTS_SVH
`define HLA_CONSTS_SVH
`define HLA_CLK_HZ 50000000
`define HLA_FS_8K_HZ 8000
`define HLA_FS_16K_HZ 16000
`define HLA_FS_32K_HZ 32000
`define HLA_FS_44K1_HZ 44100
`define HLA_FS_48K_HZ 48000
`define HLA_DIV_8K (`HLA_CLK_HZ / `HLA_FS_8K_HZ)
`define HLA_DIV_16K (`HLA_CLK_HZ / `HLA_FS_16K_HZ)
`define HLA_DIV_32K (`HLA_CLK_HZ / `HLA_FS_32K_HZ)
`define HLA_DIV_44K1 (`HLA_CLK_HZ / `HLA_FS_44K1_HZ)
`define HLA_DIV_48K (`HLA_CLK_HZ / `HLA_FS_48K_HZ)
`define HLA_DIV_W 13
`define HLA_SMP_W 16
`define HLA_CMD_W 16
`define HLA_GPIO_N 22
`define HLA_COEX_N 4
`define HLA_CAUSE_N 8
`define HLA_CAL_W 16
`define HLA_H4_SCO 8'h03
`define HLA_MSG_NONE 2'h0
`define HLA_MSG_SLEEP 2'h1
`define HLA_MSG_WAKEUP 2'h2
`define HLA_MSG_WOKEN 2'h3
`endif

//--- common/hla_pkg.sv
// Purpose: Types for the host link and audio/radio control block
// Assumes: Constants come from hla_consts.svh
// Notes: State codes are one-hot
package hla_pkg;
  typedef enum logic [1:0] {
    HLA_TP_UART = 2'h0,
    HLA_TP_UART_HS = 2'h1,
    HLA_TP_SPI = 2'h2
  } hla_transport_e;
  typedef enum logic [3:0] {
    HLA_LP_AWAKE = 4'h1,
    HLA_LP_ENTER = 4'h2,
    HLA_LP_ASLEEP = 4'h4,
    HLA_LP_WAKING = 4'h8
  } hla_lp_e;
  typedef enum logic [2:0] {
    HLA_FM_IDLE = 3'h1,
    HLA_FM_RX = 3'h2,
    HLA_FM_TX = 3'h4
  } hla_fm_e;
  typedef enum logic [1:0] {
    HLA_AP_VOICE_I2S = 2'h0,
    HLA_AP_VOICE_PCM = 2'h1,
    HLA_AP_A2DP = 2'h2
  } hla_apmode_e;
endpackage

//--- design/hla_ctrl.sv
// Purpose: Host transport power handshake, audio port framing, coex, GPIO and FM control
// Assumes: All inputs synchronous to i_ref_clk
// Notes: Serial framing and codec live outside; this block works on words
`include "hla_consts.svh"
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - UART carries H4 framing; no line error recovery is attempted.
// - Plain UART low power uses clock request, receive line and RTS.
// - Handshake UART low power uses clock request and two wake lines.
// - SPI carries H4 framing and assumes error free transfers.
// - SPI sleep control uses three messages: sleep, wakeup, woken.
// - SPI low power uses only clock request plus in-band messages.
// - Voice packets pass through HCI as well as the audio port.
// - One audio port, PCM or I2S, serving voice or A2DP.
// - Two voice links; configuring the second leaves the first running.
// - Voice frames at 8 kHz by default, optionally 16 or 32 kHz.
// - I2S voice may use only left or only right channel.
// - Two active links in I2S take one channel each.
// - Unused I2S channel slots carry zeros.
// - A2DP takes I2S audio at 44.1 or 48 kHz for internal encoding.
// - Coexistence uses one to four wires.
// - Twenty-two GPIOs, each output or interrupting input.
// - FM receive or transmit selected by host, never both.
// - FM commands come via I2C or HCI with identical encoding.
// - I2C control gives an FM interrupt pin, mapped after download, polarity set.
// - HCI control notifies with an event, no interrupt line.
// - FM interrupts raised only for causes the host enabled.
// - FM clock from slow or fast clock with handshake; optional calibration.
module hla_ctrl (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic [1:0] i_transport,
  input wire logic i_h4_valid,
  input wire logic i_h4_first,
  input wire logic [7:0] i_h4_byte,
  input wire logic i_lp_sleep,
  input wire logic i_lp_wake,
  input wire logic i_clk_ready,
  input wire logic i_uart_rxd,
  input wire logic i_uart_rts_n,
  input wire logic i_chip_wake_request,
  input wire logic i_spi_msg_valid,
  input wire logic [1:0] i_spi_msg,
  input wire logic [1:0] i_ap_mode,
  input wire logic [1:0] i_voice_rate,
  input wire logic i_a2dp_48k,
  input wire logic [1:0] i_link_en,
  input wire logic [1:0] i_link_right,
  input wire logic [1:0] i_link_hci,
  input wire logic [2*`HLA_SMP_W-1:0] i_link_smp,
  input wire logic i_hci_voice_valid,
  input wire logic i_hci_voice_link,
  input wire logic [`HLA_SMP_W-1:0] i_hci_voice,
  input wire logic [2*`HLA_SMP_W-1:0] i_port_rx,
  input wire logic [1:0] i_coex_cnt,
  input wire logic [`HLA_COEX_N-1:0] i_coex_req,
  input wire logic [`HLA_GPIO_N-1:0] i_gpio,
  input wire logic [`HLA_GPIO_N-1:0] i_gpio_dir,
  input wire logic [`HLA_GPIO_N-1:0] i_gpio_val,
  input wire logic [`HLA_GPIO_N-1:0] i_gpio_irq_en,
  input wire logic [`HLA_GPIO_N-1:0] i_gpio_clr,
  input wire logic i_fm_sel_rx,
  input wire logic i_fm_sel_tx,
  input wire logic i_fm_off,
  input wire logic i_fm_via_i2c,
  input wire logic i_i2c_cmd_valid,
  input wire logic [`HLA_CMD_W-1:0] i_i2c_cmd,
  input wire logic i_hci_cmd_valid,
  input wire logic [`HLA_CMD_W-1:0] i_hci_cmd,
  input wire logic [`HLA_CAUSE_N-1:0] i_fm_cause,
  input wire logic [`HLA_CAUSE_N-1:0] i_radio_interrupt_line_en,
  input wire logic [`HLA_CAUSE_N-1:0] i_fm_clr,
  input wire logic i_param_loaded,
  input wire logic i_irq_active_high,
  input wire logic i_fm_fast_sel,
  input wire logic i_fast_clk_avail,
  input wire logic i_cal_en,
  input wire logic i_slow_tick,
  output logic o_h4_sco_pkt,
  output logic o_clk_req,
  output logic o_host_wake_request,
  output logic o_spi_msg_valid,
  output logic [1:0] o_spi_msg,
  output logic o_lp_awake,
  output logic o_frame,
  output logic [2*`HLA_SMP_W-1:0] o_ap_tx,
  output logic o_a2dp_valid,
  output logic [2*`HLA_SMP_W-1:0] o_a2dp_smp,
  output logic o_coex_line_a,
  output logic o_coex_line_b,
  output logic o_coex_line_c,
  output logic o_coex_line_d,
  output logic [`HLA_GPIO_N-1:0] o_gpio,
  output logic [`HLA_GPIO_N-1:0] o_gpio_oe,
  output logic [`HLA_GPIO_N-1:0] o_gpio_pend,
  output logic o_fm_rx_en,
  output logic o_fm_tx_en,
  output logic o_fm_cmd_valid,
  output logic [`HLA_CMD_W-1:0] o_fm_cmd,
  output logic o_radio_interrupt_line,
  output logic o_radio_interrupt_oe,
  output logic o_fm_event,
  output logic [`HLA_CAUSE_N-1:0] o_fm_pend,
  output logic o_fm_fast_req,
  output logic o_fm_clk_fast,
  output logic o_cal_done,
  output logic [`HLA_CAL_W-1:0] o_cal_count
);
  // ----------------------------------------
  // H4 framing
  // ----------------------------------------
  // Only the type indicator is tracked; a bad byte is not recovered
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_h4_sco_pkt <= 1'b0;
    else
      o_h4_sco_pkt <= i_h4_valid && i_h4_first && i_h4_byte == `HLA_H4_SCO;
  end

  // ----------------------------------------
  // Low power handshake
  // ----------------------------------------
  hla_pkg::hla_lp_e lp_q, lp_d;
  logic tp_uart, tp_hs, tp_spi, host_wake, spi_wakeup;
  assign tp_uart = i_transport == hla_pkg::HLA_TP_UART;
  assign tp_hs = i_transport == hla_pkg::HLA_TP_UART_HS;
  assign tp_spi = i_transport == hla_pkg::HLA_TP_SPI;
  assign spi_wakeup = i_spi_msg_valid && i_spi_msg == `HLA_MSG_WAKEUP;
  assign host_wake = (tp_uart && !i_uart_rxd) || (tp_hs && i_chip_wake_request) || (tp_spi && spi_wakeup);

  always_comb
  begin
    lp_d = lp_q;
    case (lp_q)
      hla_pkg::HLA_LP_AWAKE:
        if (i_lp_sleep)
          lp_d = hla_pkg::HLA_LP_ENTER;
      hla_pkg::HLA_LP_ENTER:
        // Hold off while the host still claims the line
        if ((tp_uart && i_uart_rts_n) || (tp_hs && !i_chip_wake_request) || tp_spi)
          lp_d = hla_pkg::HLA_LP_ASLEEP;
      hla_pkg::HLA_LP_ASLEEP:
        if (host_wake || i_lp_wake)
          lp_d = hla_pkg::HLA_LP_WAKING;
      hla_pkg::HLA_LP_WAKING:
        if (i_clk_ready)
          lp_d = hla_pkg::HLA_LP_AWAKE;
      default:
        lp_d = hla_pkg::HLA_LP_AWAKE;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      lp_q <= hla_pkg::HLA_LP_AWAKE;
      o_clk_req <= 1'b1;
      o_lp_awake <= 1'b1;
      o_host_wake_request <= 1'b0;
    end
    else
    begin
      lp_q <= lp_d;
      o_clk_req <= lp_d != hla_pkg::HLA_LP_ASLEEP;
      o_lp_awake <= lp_d == hla_pkg::HLA_LP_AWAKE;
      o_host_wake_request <= tp_hs && lp_d == hla_pkg::HLA_LP_WAKING && i_lp_wake;
    end
  end

  // In-band messages: sleep on entry, wakeup when chip starts it, woken when done
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_spi_msg_valid <= 1'b0;
      o_spi_msg <= `HLA_MSG_NONE;
    end
    else
    begin
      o_spi_msg_valid <= tp_spi && lp_d != lp_q && lp_d != hla_pkg::HLA_LP_ASLEEP
        && !(lp_d == hla_pkg::HLA_LP_WAKING && !i_lp_wake);
      if (lp_d == hla_pkg::HLA_LP_ENTER)
        o_spi_msg <= `HLA_MSG_SLEEP;
      else if (lp_d == hla_pkg::HLA_LP_WAKING)
        o_spi_msg <= `HLA_MSG_WAKEUP;
      else
        o_spi_msg <= `HLA_MSG_WOKEN;
    end
  end

  a_lp_sleep_clk: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    lp_q == hla_pkg::HLA_LP_ASLEEP |-> !o_clk_req) else $error("clock request while asleep");
  a_lp_uart_wake: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    lp_q == hla_pkg::HLA_LP_ASLEEP && tp_uart && !i_uart_rxd |=> lp_q == hla_pkg::HLA_LP_WAKING ##0 o_clk_req)
    else $error("uart start bit did not wake");

  // ----------------------------------------
  // Audio port framing
  // ----------------------------------------
  logic [`HLA_DIV_W-1:0] div_cnt_q, div_top;
  logic frame_tick;
  logic [1:0] link_right_q, link_en_q;
  logic [2*`HLA_SMP_W-1:0] hci_smp_q;
  logic [`HLA_SMP_W-1:0] src0, src1, left_w, right_w;
  logic is_a2dp, is_i2s;
  assign is_a2dp = i_ap_mode == hla_pkg::HLA_AP_A2DP;
  assign is_i2s = i_ap_mode == hla_pkg::HLA_AP_VOICE_I2S;

  always_comb
  begin
    if (is_a2dp)
      div_top = i_a2dp_48k ? `HLA_DIV_W'(`HLA_DIV_48K - 1) : `HLA_DIV_W'(`HLA_DIV_44K1 - 1);
    else if (i_voice_rate == 2'h1)
      div_top = `HLA_DIV_W'(`HLA_DIV_16K - 1);
    else if (i_voice_rate == 2'h2)
      div_top = `HLA_DIV_W'(`HLA_DIV_32K - 1);
    else
      div_top = `HLA_DIV_W'(`HLA_DIV_8K - 1);
  end
  assign frame_tick = div_cnt_q >= div_top;

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      div_cnt_q <= '0;
    else if (frame_tick)
      div_cnt_q <= '0;
    else
      div_cnt_q <= div_cnt_q + `HLA_DIV_W'(1);
  end

  // Channel is latched per link on its own enable edge, so the other link is untouched
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      link_en_q <= 2'h0;
      link_right_q <= 2'h0;
    end
    else
    begin
      link_en_q <= i_link_en;
      for (int k = 0; k < 2; k++)
        if (i_link_en[k] && !link_en_q[k])
          link_right_q[k] <= i_link_right[k];
    end
  end

  // Outgoing voice taken from HCI instead of the radio path where the link is routed so
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      hci_smp_q <= '0;
    else if (i_hci_voice_valid && i_hci_voice_link)
      hci_smp_q[2*`HLA_SMP_W-1:`HLA_SMP_W] <= i_hci_voice;
    else if (i_hci_voice_valid)
      hci_smp_q[`HLA_SMP_W-1:0] <= i_hci_voice;
  end
  assign src0 = i_link_hci[0] ? hci_smp_q[`HLA_SMP_W-1:0] : i_link_smp[`HLA_SMP_W-1:0];
  assign src1 = i_link_hci[1] ? hci_smp_q[2*`HLA_SMP_W-1:`HLA_SMP_W] : i_link_smp[2*`HLA_SMP_W-1:`HLA_SMP_W];

  always_comb
  begin
    left_w = '0;
    right_w = '0;
    if (!is_i2s || link_en_q == 2'h3)
    begin
      // PCM slots or dual I2S: link 0 first slot, link 1 second
      if (link_en_q[0])
        left_w = src0;
      if (link_en_q[1])
        right_w = src1;
    end
    else if (link_en_q[0])
    begin
      if (link_right_q[0])
        right_w = src0;
      else
        left_w = src0;
    end
    else if (link_en_q[1])
    begin
      if (link_right_q[1])
        right_w = src1;
      else
        left_w = src1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_frame <= 1'b0;
      o_ap_tx <= '0;
      o_a2dp_valid <= 1'b0;
      o_a2dp_smp <= '0;
    end
    else
    begin
      o_frame <= frame_tick;
      o_a2dp_valid <= frame_tick && is_a2dp;
      if (frame_tick && !is_a2dp)
        o_ap_tx <= {right_w, left_w};
      if (frame_tick && is_a2dp)
        o_a2dp_smp <= i_port_rx;
    end
  end

  a_ap_zero_pad: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    frame_tick && !is_a2dp && link_en_q == 2'h0 |=> o_ap_tx == '0) else $error("idle slot not zero");
  a_ap_frame_8k: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    $rose(o_frame) && !is_a2dp && i_voice_rate == 2'h0 && $stable(i_voice_rate) |-> ##1 !o_frame[*8])
    else $error("frame period too short");
  a_ap_dual_i2s: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    frame_tick && is_i2s && link_en_q == 2'h3 |=> o_ap_tx == {$past(src1), $past(src0)})
    else $error("dual links not split over channels");

  // ----------------------------------------
  // Coexistence and GPIO
  // ----------------------------------------
  logic [`HLA_COEX_N-1:0] coex_mask;
  logic [`HLA_GPIO_N-1:0] gpio_prev_q, gpio_rise;
  assign coex_mask = `HLA_COEX_N'((5'h2 << i_coex_cnt) - 5'h1);
  assign gpio_rise = i_gpio & ~gpio_prev_q & ~i_gpio_dir & i_gpio_irq_en;

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      {o_coex_line_d, o_coex_line_c, o_coex_line_b, o_coex_line_a} <= '0;
      // Reset high so a pin already high after reset is not taken as an edge
      gpio_prev_q <= '1;
      o_gpio <= '0;
      o_gpio_oe <= '0;
      o_gpio_pend <= '0;
    end
    else
    begin
      {o_coex_line_d, o_coex_line_c, o_coex_line_b, o_coex_line_a} <= i_coex_req & coex_mask;
      gpio_prev_q <= i_gpio;
      o_gpio <= i_gpio_val & i_gpio_dir;
      o_gpio_oe <= i_gpio_dir;
      o_gpio_pend <= (o_gpio_pend & ~i_gpio_clr) | gpio_rise;
    end
  end

  a_gpio_set_wins: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (gpio_rise & i_gpio_clr) != '0 |=> (o_gpio_pend & $past(gpio_rise)) == $past(gpio_rise))
    else $error("gpio event lost to clear");
  a_coex_width: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_coex_cnt == 2'h0 |=> !o_coex_line_b && !o_coex_line_c && !o_coex_line_d)
    else $error("unused coex wire driven");

  // ----------------------------------------
  // FM function select and commands
  // ----------------------------------------
  hla_pkg::hla_fm_e fm_q, fm_d;
  always_comb
  begin
    fm_d = fm_q;
    case (fm_q)
      hla_pkg::HLA_FM_IDLE:
        if (i_fm_sel_rx && !i_fm_off)
          fm_d = hla_pkg::HLA_FM_RX;
        else if (i_fm_sel_tx && !i_fm_off)
          fm_d = hla_pkg::HLA_FM_TX;
      // Switching passes through idle so both paths are never enabled together
      hla_pkg::HLA_FM_RX:
        if (i_fm_off || i_fm_sel_tx)
          fm_d = hla_pkg::HLA_FM_IDLE;
      hla_pkg::HLA_FM_TX:
        if (i_fm_off || i_fm_sel_rx)
          fm_d = hla_pkg::HLA_FM_IDLE;
      default:
        fm_d = hla_pkg::HLA_FM_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      fm_q <= hla_pkg::HLA_FM_IDLE;
      o_fm_rx_en <= 1'b0;
      o_fm_tx_en <= 1'b0;
      o_fm_cmd_valid <= 1'b0;
      o_fm_cmd <= '0;
    end
    else
    begin
      fm_q <= fm_d;
      o_fm_rx_en <= fm_d == hla_pkg::HLA_FM_RX;
      o_fm_tx_en <= fm_d == hla_pkg::HLA_FM_TX;
      o_fm_cmd_valid <= i_fm_via_i2c ? i_i2c_cmd_valid : i_hci_cmd_valid;
      if (i_fm_via_i2c && i_i2c_cmd_valid)
        o_fm_cmd <= i_i2c_cmd;
      else if (!i_fm_via_i2c && i_hci_cmd_valid)
        o_fm_cmd <= i_hci_cmd;
    end
  end

  a_fm_exclusive: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    !(o_fm_rx_en && o_fm_tx_en)) else $error("fm rx and tx both on");
  a_fm_cmd_path: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_fm_via_i2c && i_i2c_cmd_valid |=> o_fm_cmd_valid && o_fm_cmd == $past(i_i2c_cmd))
    else $error("i2c command not passed");

  // ----------------------------------------
  // FM interrupt and event
  // ----------------------------------------
  logic [`HLA_CAUSE_N-1:0] fm_set, fm_pend_d;
  logic irq_any;
  assign fm_set = i_fm_cause & i_radio_interrupt_line_en;
  assign fm_pend_d = (o_fm_pend & ~i_fm_clr) | fm_set;
  assign irq_any = |(fm_pend_d & i_radio_interrupt_line_en);

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_fm_pend <= '0;
      o_radio_interrupt_line <= 1'b0;
      o_radio_interrupt_oe <= 1'b0;
      o_fm_event <= 1'b0;
    end
    else
    begin
      o_fm_pend <= fm_pend_d;
      // Pin stays unmapped until the parameter download has completed
      o_radio_interrupt_oe <= i_fm_via_i2c && i_param_loaded;
      o_radio_interrupt_line <= (i_fm_via_i2c && irq_any) ~^ i_irq_active_high ? 1'b1 : 1'b0;
      o_fm_event <= !i_fm_via_i2c && (fm_set & ~o_fm_pend) != '0;
    end
  end

  sequence s_cause_raised;
    i_fm_via_i2c && i_param_loaded && (fm_set != '0);
  endsequence
  sequence s_line_active;
    o_radio_interrupt_oe && o_radio_interrupt_line == i_irq_active_high;
  endsequence
  a_irq_level: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    s_cause_raised ##1 (i_fm_via_i2c && i_param_loaded && $stable(i_irq_active_high)) |-> s_line_active)
    else $error("fm interrupt not active");
  a_irq_masked: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_fm_cause & ~i_radio_interrupt_line_en & ~o_fm_pend) != '0 && fm_set == '0 && (o_fm_pend & ~i_fm_clr) == '0
    |=> o_fm_pend == '0) else $error("disabled cause latched");
  a_hci_no_line: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    !i_fm_via_i2c |=> !o_radio_interrupt_oe) else $error("line used in hci mode");

  // ----------------------------------------
  // FM reference clock and calibration
  // ----------------------------------------
  logic [`HLA_CAL_W-1:0] cal_cnt_q;
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_fm_fast_req <= 1'b0;
      o_fm_clk_fast <= 1'b0;
      cal_cnt_q <= '0;
      o_cal_count <= '0;
      o_cal_done <= 1'b0;
    end
    else
    begin
      o_fm_fast_req <= i_fm_fast_sel;
      // Use fast clock only once the radio side reports it available
      o_fm_clk_fast <= i_fm_fast_sel && i_fast_clk_avail;
      // Fast cycles per slow tick gives the slow clock error
      o_cal_done <= i_cal_en && i_fast_clk_avail && i_slow_tick;
      if (!i_cal_en || !i_fast_clk_avail)
        cal_cnt_q <= '0;
      else if (i_slow_tick)
        // Restart at one so the count spans the whole slow period
        cal_cnt_q <= `HLA_CAL_W'(1);
      else if (cal_cnt_q != '1)
        cal_cnt_q <= cal_cnt_q + `HLA_CAL_W'(1);
      if (i_cal_en && i_fast_clk_avail && i_slow_tick)
        o_cal_count <= cal_cnt_q;
    end
  end

  a_fm_clk_avail: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    !i_fast_clk_avail |=> !o_fm_clk_fast) else $error("fast clock used while absent");
endmodule
`default_nettype wire

//--- verification/hla_ctrl_tb_top.sv
// Purpose: Self-checking bench for hla_ctrl
// Assumes: Host model drives the wake wires
// Notes: Voice frames run full length, so waits are long
`include "hla_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module hla_ctrl_tb_top;
  logic i_ref_clk = '0, i_rstn = '0, wake = '0;
  logic i_h4_valid = '0, i_h4_first = '0, i_lp_sleep = '0, i_lp_wake = '0, i_clk_ready = '0;
  logic i_spi_msg_valid = '0, i_a2dp_48k = '0, i_hci_voice_valid = '0, i_hci_voice_link = '0;
  logic i_fm_sel_rx = '0, i_fm_sel_tx = '0, i_fm_off = '0, i_fm_via_i2c = '0, i_i2c_cmd_valid = '0;
  logic i_hci_cmd_valid = '0, i_param_loaded = '0, i_irq_active_high = '0, i_fm_fast_sel = '0;
  logic i_fast_clk_avail = '0, i_cal_en = '0, i_slow_tick = '0;
  logic [1:0] i_transport = '0, i_spi_msg = '0, i_ap_mode = '0, i_voice_rate = '0, i_link_en = '0;
  logic [1:0] i_link_right = '0, i_link_hci = '0, i_coex_cnt = '0;
  logic [3:0] i_coex_req = '0;
  logic [7:0] i_h4_byte = '0, i_fm_cause = '0, i_radio_interrupt_line_en = '0, i_fm_clr = '0;
  logic [15:0] i_hci_voice = '0, i_i2c_cmd = '0, i_hci_cmd = '0;
  logic [31:0] i_link_smp = '0, i_port_rx = '0;
  logic [21:0] i_gpio = '0, i_gpio_dir = '0, i_gpio_val = '0, i_gpio_irq_en = '0, i_gpio_clr = '0;
  wire i_uart_rxd, i_uart_rts_n, i_chip_wake_request;
  logic o_h4_sco_pkt, o_clk_req, o_host_wake_request, o_spi_msg_valid, o_lp_awake, o_frame;
  logic o_a2dp_valid, o_coex_line_a, o_coex_line_b, o_coex_line_c, o_coex_line_d, o_fm_rx_en;
  logic o_fm_tx_en, o_fm_cmd_valid, o_radio_interrupt_line, o_radio_interrupt_oe, o_fm_event;
  logic o_fm_fast_req, o_fm_clk_fast, o_cal_done;
  logic [1:0] o_spi_msg;
  logic [7:0] o_fm_pend;
  logic [15:0] o_fm_cmd, o_cal_count;
  logic [21:0] o_gpio, o_gpio_oe, o_gpio_pend;
  logic [31:0] o_ap_tx, o_a2dp_smp;
  int fails = 0, comparisons = 0, cyc = 0, n;
  hla_ctrl dut_u (.*);
  hla_host_model host_u (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_transport(i_transport),
    .i_wake(wake), .o_uart_rxd(i_uart_rxd), .o_uart_rts_n(i_uart_rts_n),
    .o_chip_wake_request(i_chip_wake_request));
  initial forever #10 i_ref_clk = ~i_ref_clk;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x)
    begin
      fails++;
      $display("MISMATCH %0t got %h expected %h", $time, g, x);
    end
  endtask
  task e(input int k = 1);
    repeat (k) @(posedge i_ref_clk);
  endtask
  task s(input int k = 1);
    repeat (k) @(posedge i_ref_clk);
    #1;
  endtask
  // Pulses may last one cycle, so look first in the calling cycle
  task automatic wt(ref logic sig, input int lim);
    n = 0;
    #1;
    while (sig !== 1'b1 && n < lim)
    begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
  endtask
  task results;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge i_ref_clk)
  begin
    cyc++;
    if ({o_fm_rx_en, o_fm_tx_en} === 2'h3)
      chk(1'h1, 1'h0);
    if (cyc == 40000)
    begin
      fails++;
      results;
    end
  end
  initial
  begin
    e(8);
    i_rstn <= 1'h1;
    s;
    chk({o_clk_req, o_lp_awake, o_radio_interrupt_oe}, 3'h6);
    e;
    {i_transport, i_clk_ready, i_lp_sleep} <= 4'hB;
    wt(o_spi_msg_valid, 10);
    chk(o_spi_msg, `HLA_MSG_SLEEP);
    e;
    i_lp_sleep <= 1'h0;
    s(3);
    chk(o_clk_req, 1'h0);
    e;
    {i_spi_msg_valid, i_spi_msg} <= {1'h1, `HLA_MSG_WAKEUP};
    e;
    i_spi_msg_valid <= 1'h0;
    wt(o_spi_msg_valid, 10);
    chk({o_spi_msg, o_lp_awake}, {`HLA_MSG_WOKEN, 1'h1});
    for (int m = 0; m < 2; m++)
    begin
      e;
      {i_transport, i_lp_sleep} <= {m[1:0], 1'h1};
      s(4);
      chk(o_clk_req, 1'h0);
      e;
      {i_lp_sleep, wake} <= 2'h1;
      s(6);
      chk({o_clk_req, o_lp_awake}, 2'h3);
      e;
      wake <= 1'h0;
    end
    e;
    {i_lp_sleep, i_clk_ready} <= 2'h2;
    e(3);
    {i_lp_sleep, i_lp_wake} <= 2'h1;
    wt(o_host_wake_request, 4);
    chk({n < 4, o_clk_req}, 2'h3);
    e;
    {i_lp_wake, i_clk_ready} <= 2'h1;
    for (int b = 2; b < 4; b++)
    begin
      e;
      {i_h4_valid, i_h4_first, i_h4_byte} <= {2'h3, b[7:0]};
      e;
      i_h4_valid <= 1'h0;
      wt(o_h4_sco_pkt, 4);
      chk(n < 4, b == 3);
    end
    for (int p = 0; p < 2; p++)
    begin
      e;
      {i_fm_via_i2c, i_i2c_cmd_valid, i_hci_cmd_valid} <= {p == 0, 2'h3};
      {i_i2c_cmd, i_hci_cmd} <= p ? 32'h1235_1234 : 32'h1234_1235;
      e;
      {i_i2c_cmd_valid, i_hci_cmd_valid} <= 2'h0;
      s;
      chk(o_fm_cmd, 16'h1234);
      e;
      // Held two cycles: a swap passes through idle first
      {i_fm_sel_rx, i_fm_sel_tx} <= p ? 2'h1 : 2'h2;
      e(2);
      {i_fm_sel_rx, i_fm_sel_tx} <= 2'h0;
      s(3);
      chk({o_fm_rx_en, o_fm_tx_en}, p ? 2'h1 : 2'h2);
    end
    e;
    {i_fm_via_i2c, i_param_loaded, i_radio_interrupt_line_en, i_fm_cause} <= {2'h3, 8'h01, 8'h02};
    e;
    i_fm_cause <= 8'h00;
    s(2);
    chk({o_radio_interrupt_line, o_radio_interrupt_oe, o_fm_pend}, 10'h300);
    e;
    i_fm_cause <= 8'h01;
    e;
    i_fm_cause <= 8'h00;
    s(6);
    chk({o_radio_interrupt_line, o_radio_interrupt_oe}, 2'h1);
    e;
    i_fm_clr <= 8'h01;
    e;
    i_fm_clr <= 8'h00;
    s(2);
    chk(o_radio_interrupt_line, 1'h1);
    e;
    {i_fm_via_i2c, i_radio_interrupt_line_en, i_fm_cause} <= {1'h0, 8'h04, 8'h04};
    e;
    i_fm_cause <= 8'h00;
    wt(o_fm_event, 4);
    chk({n < 4, o_radio_interrupt_oe}, 2'h2);
    e;
    {i_coex_cnt, i_coex_req, i_gpio_dir, i_gpio_val} <= {2'h1, 4'hF, 22'h00000F, 22'h000005};
    {i_gpio_irq_en, i_gpio, i_gpio_clr, i_fm_fast_sel, i_cal_en} <= {22'h000030, 22'h000010, 22'h000010, 2'h3};
    e;
    {i_gpio, i_gpio_clr, i_fast_clk_avail, i_slow_tick} <= {22'h000070, 22'h000010, 2'h3};
    e;
    {i_gpio_clr, i_slow_tick} <= 23'h0;
    s;
    chk({o_coex_line_d, o_coex_line_c, o_coex_line_b, o_coex_line_a}, 4'h3);
    chk(o_gpio, 22'h000005);
    chk(o_gpio_oe, 22'h00000F);
    chk(o_gpio_pend, 22'h000020);
    e(7);
    i_slow_tick <= 1'h1;
    e;
    i_slow_tick <= 1'h0;
    wt(o_cal_done, 2);
    chk({n[1:0], o_cal_count, o_fm_clk_fast, o_fm_fast_req}, {2'h0, 16'h0009, 2'h3});
    e;
    {i_link_right, i_link_smp} <= {2'h1, 32'h1111_5A5A};
    e;
    i_link_en <= 2'h1;
    wt(o_frame, 7000);
    s;
    wt(o_frame, 7000);
    chk(o_ap_tx, 32'h5A5A_0000);
    e;
    {i_link_en, i_voice_rate} <= 4'hD;
    for (int r = 0; r < 3; r++)
    begin
      s;
      wt(o_frame, 7000);
    end
    chk(o_ap_tx, 32'h1111_5A5A);
    chk(n, `HLA_DIV_16K - 1);
    e;
    {i_ap_mode, i_a2dp_48k, i_port_rx} <= {2'h2, 1'h1, 32'hC3C3_3C3C};
    wt(o_a2dp_valid, 1200);
    s;
    wt(o_a2dp_valid, 1200);
    chk(o_a2dp_smp, 32'hC3C3_3C3C);
    chk(n, `HLA_DIV_48K - 1);
    results;
  end
endmodule
`default_nettype wire

//--- verification/hla_host_model.sv
// Purpose: Host side of the low power wake wires
// Assumes: Bench raises i_wake as a level
// Notes: UART lines idle high like a UART at rest; chip wake request idles low
`timescale 1ns/100ps
`default_nettype none
module hla_host_model (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic [1:0] i_transport,
  input wire logic i_wake,
  output logic o_uart_rxd,
  output logic o_uart_rts_n,
  output logic o_chip_wake_request
);
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_uart_rxd <= 1'h1;
      o_uart_rts_n <= 1'h1;
      o_chip_wake_request <= 1'h0;
    end
    else
    begin
      // Start bit and RTS only used as wake in plain mode
      o_uart_rxd <= !(i_wake && i_transport == 2'h0);
      o_uart_rts_n <= !(i_wake && i_transport == 2'h0);
      o_chip_wake_request <= i_wake && i_transport == 2'h1;
    end
  end
endmodule
`default_nettype wire
